//--- gpio_port_pkg.sv
package gpio_port_pkg;

    // ------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int NPINS = 5;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_DATA_OUT = 12'h000;
    localparam logic [11:0] OFS_DIRECTION = 12'h004;
    localparam logic [11:0] OFS_INT_ENABLE = 12'h008;
    localparam logic [11:0] OFS_TRIG_MODE = 12'h00c;
    localparam logic [11:0] OFS_POLARITY = 12'h010;
    localparam logic [11:0] OFS_BOTH_EDGES = 12'h014;
    localparam logic [11:0] OFS_PIN_LEVEL = 12'h018;
    localparam logic [11:0] OFS_RAW_STATUS = 12'h01c;
    localparam logic [11:0] OFS_MASKED_STATUS = 12'h020;
    localparam logic [11:0] OFS_CONTROL = 12'h024;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int CTRL_SOFT_RST_BIT = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [4:0] RST_PIN_FIELD = 5'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
    localparam logic [4:0] TRIG_EDGE_ALL = 5'h00;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    // edges after reset before pin history can be trusted
    localparam logic [1:0] SYNC_WARM = 2'h3;

endpackage

//--- pin_sync.sv
`timescale 1ns/100ps

module pin_sync
    import gpio_port_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // async pins in, synchronous copy out
    input wire logic [NPINS-1:0] async_in,
    output logic [NPINS-1:0] sync_out
);

    logic [NPINS-1:0] meta_reg;
    logic [NPINS-1:0] sync_reg;

    // --------------------------------------------------------
    // two flip-flop synchroniser
    // --------------------------------------------------------
    // first stage is read only by the second stage
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= RST_PIN_FIELD;
            sync_reg <= RST_PIN_FIELD;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

//--- gpio_port.sv
//
// Function
// - only the low five of eight port bits work; upper three are reserved
// - software sets each pin's direction individually, input or output
// - each input pin is an interrupt source with its own control
// - each output pin drives its own software-chosen level, low or high
// - software reads both raw and masked interrupt status
// - while asleep, any change of an enabled input raises the interrupt
// - reset clears every per-pin interrupt enable bit
// - reset clears all registers and makes every pin an input
// - after reset every pin's trigger mode is edge-sensitive
// - the whole port runs synchronously on the one bus clock
// - port reset on chip reset, subsystem reset or port soft reset
// - no per-pin soft reset; reset always acts on the whole port
//
`timescale 1ns/100ps

module gpio_port
    import gpio_port_pkg::*;
(
    // clock and chip reset
    input wire logic clock_in,
    input wire logic rst_in,
    // synchronous subsystem reset
    input wire logic subsys_rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [DATA_W-1:0] pwdata_in,
    output logic [DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // pins
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe_out,
    // interrupt and wake
    output logic irq_out,
    output logic wake_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NPINS-1:0] dout;
        logic [NPINS-1:0] dir;
        logic [NPINS-1:0] ie;
        logic [NPINS-1:0] trig;
        logic [NPINS-1:0] pol;
        logic [NPINS-1:0] both;
        logic sleep;
        logic [NPINS-1:0] raw;
        logic [NPINS-1:0] prev;
        logic [1:0] warm;
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic err;
        logic irq;
        logic wake;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic [NPINS-1:0] pin_sync_w;

    // widen a pin field into a bus word, upper bits zero
    function automatic logic [DATA_W-1:0] widen(input logic [NPINS-1:0] f);
        widen = {{(DATA_W-NPINS){1'b0}}, f};
    endfunction

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    pin_sync u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(pin_in),
        .sync_out(pin_sync_w)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic setup;
        logic access;
        logic wr;
        logic rd;
        logic [NPINS-1:0] rise;
        logic [NPINS-1:0] fall;
        logic [NPINS-1:0] edge_hit;
        logic [NPINS-1:0] level_hit;
        logic [NPINS-1:0] hit;
        logic [NPINS-1:0] wd;
        rise = '0;
        fall = '0;
        edge_hit = '0;
        level_hit = '0;
        hit = '0;
        setup = psel_in & ~penable_in;
        access = psel_in & penable_in & st_reg.ready;
        wr = access & pwrite_in;
        rd = access & ~pwrite_in;
        wd = pwdata_in[NPINS-1:0];
        st_next = st_reg;
        // apb answer is prepared in the setup cycle
        st_next.ready = setup;
        st_next.err = 1'b0; // error stands only with ready
        if (setup) begin
            unique case (paddr_in)
                OFS_DATA_OUT: st_next.rdata = widen(st_reg.dout);
                OFS_DIRECTION: st_next.rdata = widen(st_reg.dir);
                OFS_INT_ENABLE: st_next.rdata = widen(st_reg.ie);
                OFS_TRIG_MODE: st_next.rdata = widen(st_reg.trig);
                OFS_POLARITY: st_next.rdata = widen(st_reg.pol);
                OFS_BOTH_EDGES: st_next.rdata = widen(st_reg.both);
                OFS_PIN_LEVEL: st_next.rdata = widen(pin_sync_w);
                OFS_RAW_STATUS: st_next.rdata = widen(st_reg.raw);
                OFS_MASKED_STATUS: begin
                    st_next.rdata = widen(st_reg.raw & st_reg.ie);
                end
                OFS_CONTROL: st_next.rdata = widen({4'h0, st_reg.sleep});
                default: begin
                    st_next.rdata = RST_RDATA;
                    st_next.err = 1'b1;
                end
            endcase
        end
        // register writes take effect at the access edge
        if (wr) begin
            unique case (paddr_in)
                OFS_DATA_OUT: st_next.dout = wd;
                OFS_DIRECTION: st_next.dir = wd;
                OFS_INT_ENABLE: st_next.ie = wd;
                OFS_TRIG_MODE: st_next.trig = wd;
                OFS_POLARITY: st_next.pol = wd;
                OFS_BOTH_EDGES: st_next.both = wd;
                OFS_CONTROL: st_next.sleep = pwdata_in[CTRL_SLEEP_BIT];
                default: st_next.sleep = st_reg.sleep;
            endcase
        end
        // event detection on synchronised inputs only
        rise = pin_sync_w & ~st_reg.prev;
        fall = ~pin_sync_w & st_reg.prev;
        edge_hit = (rise & ~st_reg.pol) | (fall & st_reg.pol)
            | ((rise | fall) & st_reg.both);
        level_hit = pin_sync_w ^ st_reg.pol;
        hit = ((edge_hit & ~st_reg.trig) | (level_hit & st_reg.trig))
            & ~st_reg.dir;
        if (st_reg.sleep) begin
            hit = hit | ((rise | fall) & st_reg.ie & ~st_reg.dir);
        end
        // no false edge while sync chain and history still hold reset
        if (st_reg.warm != SYNC_WARM) begin
            hit = '0;
            st_next.warm = st_reg.warm + 2'h1;
        end
        st_next.prev = pin_sync_w;
        // read clears only the bits reported; a new event wins
        if (rd && paddr_in == OFS_RAW_STATUS) begin
            st_next.raw = st_reg.raw & ~st_reg.rdata[NPINS-1:0];
        end
        st_next.raw = st_next.raw | hit;
        // whole-port soft or subsystem reset
        if (subsys_rst_in
            || (wr && paddr_in == OFS_CONTROL
                && pwdata_in[CTRL_SOFT_RST_BIT])) begin
            st_next.dout = RST_PIN_FIELD;
            st_next.dir = RST_PIN_FIELD;
            st_next.ie = RST_PIN_FIELD;
            st_next.trig = TRIG_EDGE_ALL;
            st_next.pol = RST_PIN_FIELD;
            st_next.both = RST_PIN_FIELD;
            st_next.sleep = 1'b0;
            st_next.raw = RST_PIN_FIELD;
        end
        st_next.irq = |(st_next.raw & st_next.ie);
        st_next.wake = st_next.irq & st_next.sleep;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // single clock domain, async chip reset
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign prdata_out = st_reg.rdata;
    assign pready_out = st_reg.ready;
    assign pslverr_out = st_reg.err;
    assign pin_out = st_reg.dout;
    assign pin_oe_out = st_reg.dir;
    assign irq_out = st_reg.irq;
    assign wake_out = st_reg.wake;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    logic wr_a;
    logic sr_a;
    assign wr_a = psel_in & penable_in & pready_out & pwrite_in;
    assign sr_a = wr_a && paddr_in == OFS_CONTROL
        && pwdata_in[CTRL_SOFT_RST_BIT];

    property p_upper_zero;
        pready_out |-> prdata_out[DATA_W-1:NPINS] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("reserved read bits not zero");

    property p_dir_write;
        (wr_a && paddr_in == OFS_DIRECTION && !subsys_rst_in)
            |=> pin_oe_out == $past(pwdata_in[NPINS-1:0]);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not seen on enables");

    property p_dout_write;
        (wr_a && paddr_in == OFS_DATA_OUT && !subsys_rst_in)
            |=> pin_out == $past(pwdata_in[NPINS-1:0]);
    endproperty
    a_dout_write: assert property (p_dout_write)
        else $error("data write not seen on pins");

    property p_masked_read;
        (psel_in && !penable_in && paddr_in == OFS_MASKED_STATUS)
            |=> prdata_out[NPINS-1:0] == $past(st_reg.raw & st_reg.ie);
    endproperty
    a_masked_read: assert property (p_masked_read)
        else $error("masked status read wrong");

    property p_irq_or;
        irq_out == |(st_reg.raw & st_reg.ie);
    endproperty
    a_irq_or: assert property (p_irq_or)
        else $error("interrupt is not or of masked bits");

    property p_soft_reset;
        sr_a |=> (pin_oe_out == '0 && st_reg.ie == '0 && !irq_out
            && st_reg.trig == TRIG_EDGE_ALL)[*2];
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset left state behind");

    property p_no_enable_no_irq;
        st_reg.ie == '0 |-> !irq_out;
    endproperty
    a_no_enable_no_irq: assert property (p_no_enable_no_irq)
        else $error("interrupt with no enable set");

    property p_sleep_wake;
        (st_reg.sleep && |((pin_sync_w ^ st_reg.prev) & st_reg.ie
            & ~st_reg.dir) && st_reg.warm == SYNC_WARM
            && !subsys_rst_in && !sr_a
            && !(wr_a && (paddr_in == OFS_CONTROL
                || paddr_in == OFS_INT_ENABLE)))
            |=> irq_out && wake_out;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("no wake on input change in sleep");

    property p_sync_only;
        (st_reg.raw == '0 && st_reg.trig == '0 && !st_reg.sleep
            && pin_sync_w == st_reg.prev) |=> st_reg.raw == '0;
    endproperty
    a_sync_only: assert property (p_sync_only)
        else $error("edge event without synchronised change");

    property p_out_no_status;
        st_reg.dir != '0
            |=> (st_reg.raw & ~$past(st_reg.raw) & $past(st_reg.dir)) == '0;
    endproperty
    a_out_no_status: assert property (p_out_no_status)
        else $error("output pin set interrupt status");

    property p_warm_quiet;
        (st_reg.warm != SYNC_WARM && st_reg.raw == '0) |=> st_reg.raw == '0;
    endproperty
    a_warm_quiet: assert property (p_warm_quiet)
        else $error("status set before synchroniser settled");

    property p_level_hold;
        (|(st_reg.trig & ~st_reg.dir & (pin_sync_w ^ st_reg.pol))
            && st_reg.warm == SYNC_WARM && !subsys_rst_in && !sr_a)
            |=> st_reg.raw != '0;
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("active level did not hold status");

    c_wake: cover property (st_reg.sleep ##1 wake_out);
    c_read_clear: cover property (st_reg.raw != '0 ##[1:8] st_reg.raw == '0);
    c_unmapped: cover property (pslverr_out);
    c_level_irq: cover property (st_reg.trig != '0 && irq_out);

endmodule

//--- gpio_periph_model.sv
`timescale 1ns/100ps

module gpio_periph_model (
    // port side of the pins
    input wire logic [4:0] dev_level_in,
    input wire logic [4:0] dev_oe_in,
    // level the peripheral puts on each pin
    input wire logic [4:0] drive_in,
    // resolved wire level
    output logic [4:0] level_out
);
    // ----------------------------------------------------------------
    // pin resolution
    // ----------------------------------------------------------------
    // port wins where it drives, peripheral holds the other pins
    assign level_out = (dev_oe_in & dev_level_in) | (~dev_oe_in & drive_in);
endmodule

//--- tb_top.sv
`timescale 1ns/100ps

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_top;
    import gpio_port_pkg::*;
    logic clock_in, rst_in, subsys_rst_in, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic pready, pslverr, irq, wake;
    logic [4:0] level, pin_out, pin_oe, drive, dir, dat;
    logic [33:0] expq[$];
    logic [33:0] e;
    int errors, checked, cycles;

    // ----------------------------------------------------------------
    // design and peripheral
    // ----------------------------------------------------------------
    gpio_port u_dut (.clock_in(clock_in), .rst_in(rst_in),
        .subsys_rst_in(subsys_rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .pin_in(level), .pin_out(pin_out),
        .pin_oe_out(pin_oe), .irq_out(irq), .wake_out(wake));
    gpio_periph_model u_periph (.dev_level_in(pin_out),
        .dev_oe_in(pin_oe), .drive_in(drive), .level_out(level));

    // clock generation
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    // answer monitor, oldest note first
    always @(posedge clock_in) begin
        cycles++;
        if (psel && penable && pready) begin
            e = expq.pop_front();
            `CHK(pslverr, e[32])
            if (e[33]) `CHK(prdata, e[31:0])
        end
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, input logic [32:0] x);
        @(posedge clock_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        expq.push_back({~w, x});
        @(posedge clock_in);
        penable <= 1'b1;
        do begin
            @(posedge clock_in);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {1'b0, x});
    endtask

    task automatic results();
        if (errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_in = 1'b1;
        subsys_rst_in = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        drive = 5'h00;
        errors = 0;
        checked = 0;
        cycles = 0;
        void'($urandom(71));
        repeat (12) @(posedge clock_in);
        rst_in <= 1'b0;
        // every register clears, all pins inputs
        for (int i = 0; i < 10; i++) rd(12'(i * 4), 32'h0);
        `CHK(pin_oe, 5'h00)
        apb(1'b0, 12'h028, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h040, 32'hffff_ffff, {1'b1, 32'h0});
        // random directions and output levels
        repeat (6) begin
            d = $urandom;
            dir = 5'($urandom);
            dat = d[4:0];
            drive <= 5'($urandom);
            wr(OFS_DIRECTION, {27'h0, dir});
            wr(OFS_DATA_OUT, d);
            repeat (4) @(posedge clock_in);
            `CHK(pin_oe, dir)
            `CHK(pin_out, dat)
            rd(OFS_PIN_LEVEL, {27'h0, (dir & dat) | (~dir & drive)});
            rd(OFS_DATA_OUT, {27'h0, dat});
        end
        // port soft reset clears the whole port
        drive <= 5'h00;
        repeat (4) @(posedge clock_in);
        wr(OFS_CONTROL, 32'h2);
        rd(OFS_DIRECTION, 32'h0);
        rd(OFS_INT_ENABLE, 32'h0);
        `CHK(pin_oe, 5'h00)
        // pin 0 enabled, pin 1 masked
        wr(OFS_INT_ENABLE, 32'h1);
        drive <= 5'h03;
        repeat (6) @(posedge clock_in);
        `CHK(irq, 1'b1)
        rd(OFS_MASKED_STATUS, 32'h1);
        rd(OFS_RAW_STATUS, 32'h3);
        rd(OFS_RAW_STATUS, 32'h0);
        @(posedge clock_in);
        `CHK(irq, 1'b0)
        // wake from sleep on a rise of enabled pin 2
        wr(OFS_INT_ENABLE, 32'h4);
        wr(OFS_CONTROL, 32'h1);
        @(posedge clock_in);
        `CHK(wake, 1'b0)
        drive <= 5'h07;
        repeat (6) @(posedge clock_in);
        `CHK(wake, 1'b1)
        // subsystem reset
        subsys_rst_in <= 1'b1;
        @(posedge clock_in);
        subsys_rst_in <= 1'b0;
        @(posedge clock_in);
        `CHK(wake, 1'b0)
        `CHK(irq, 1'b0)
        rd(OFS_CONTROL, 32'h0);
        // falling, both-edge and level triggers
        wr(OFS_POLARITY, 32'h1);
        wr(OFS_BOTH_EDGES, 32'h2);
        wr(OFS_INT_ENABLE, 32'h3);
        drive <= 5'h04;
        repeat (6) @(posedge clock_in);
        `CHK(irq, 1'b1)
        rd(OFS_MASKED_STATUS, 32'h3);
        rd(OFS_RAW_STATUS, 32'h3);
        drive <= 5'h07;
        repeat (6) @(posedge clock_in);
        rd(OFS_RAW_STATUS, 32'h2);
        wr(OFS_TRIG_MODE, 32'h1);
        drive <= 5'h06;
        repeat (6) @(posedge clock_in);
        rd(OFS_RAW_STATUS, 32'h1);
        rd(OFS_RAW_STATUS, 32'h1);
        drive <= 5'h07;
        repeat (6) @(posedge clock_in);
        rd(OFS_RAW_STATUS, 32'h1);
        rd(OFS_RAW_STATUS, 32'h0);
        // chip reset in mid-run acts without a clock edge
        wr(OFS_DIRECTION, 32'h1f);
        @(negedge clock_in);
        `CHK(pin_oe, 5'h1f)
        @(posedge clock_in);
        rst_in <= 1'b1;
        @(negedge clock_in);
        `CHK(pin_oe, 5'h00)
        @(posedge clock_in);
        rst_in <= 1'b0;
        rd(OFS_DIRECTION, 32'h0);
        // high pins after reset must not look like edges
        repeat (6) @(posedge clock_in);
        rd(OFS_RAW_STATUS, 32'h0);
        results();
    end
endmodule
